// ===== rtl/orx_pkg.sv
package orx_pkg;

    // ==========================================================
    // Widths
    localparam int DATA_W = 8;
    localparam int FILE_AW = 6;
    localparam int AUX_IW = 4;
    localparam int PC_W = 10;

    // ==========================================================
    // Auxiliary page
    localparam int AUX_DEPTH = 16;
    localparam logic [AUX_IW-1:0] AUX_LOAD_MIN = 4'h5;
    localparam logic [DATA_W-1:0] AUX_RESET = 8'h00;

    // ==========================================================
    // Hardware stack, program counter
    localparam int STACK_DEPTH = 4;
    localparam int SP_W = 2;
    localparam logic [PC_W-1:0] PC_RESET = 10'h000;
    localparam logic [PC_W-1:0] PC_STEP = 10'h001;
    localparam logic [SP_W-1:0] SP_STEP = 2'h1;

    // ==========================================================
    // Operations handled by this block
    typedef enum logic [2:0] {
        OP_OR_WORK_WITH_FILE,
        OP_OR_WORK_WITH_LITERAL,
        OP_AUX_PAGE_LOAD_TO_WORK,
        OP_AUX_PAGE_STORE_FROM_WORK,
        OP_LONG_SUBROUTINE_JUMP
    } orx_op_t;

    typedef enum logic {
        ST_ISSUE,
        ST_CALL_LOAD
    } orx_state_t;

endpackage

// ===== rtl/orx_aux_if.sv
`timescale 1ns/1ns
interface orx_aux_if;
    import orx_pkg::*;
    logic wr_en;
    logic [AUX_IW-1:0] wr_idx;
    logic [DATA_W-1:0] wr_data;
    logic [AUX_IW-1:0] rd_idx;
    logic [DATA_W-1:0] rd_data;

    modport core (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
    modport page (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

// ===== rtl/orx_aux_page.sv
`timescale 1ns/1ns
module orx_aux_page
    import orx_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Core side
    orx_aux_if.page aux
);

    typedef struct packed {
        logic [AUX_DEPTH-1:0][DATA_W-1:0] regs;
    } orx_aux_state_t;

    orx_aux_state_t st_r;
    orx_aux_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (aux.wr_en) begin
            st_nxt.regs[aux.wr_idx] = aux.wr_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '{regs: {AUX_DEPTH{AUX_RESET}}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Read is combinational so a load completes in the issuing cycle
    assign aux.rd_data = st_r.regs[aux.rd_idx];

endmodule

// ===== rtl/orx_exec.sv
// ==========================================================
`timescale 1ns/1ns
module orx_exec
    import orx_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // Instruction issue
    input wire logic INSTR_VALID,
    input wire orx_op_t INSTR_OP,
    input wire logic [FILE_AW-1:0] INSTR_FILE_ADDR,
    input wire logic [DATA_W-1:0] INSTR_FILE_DATA,
    input wire logic INSTR_DEST,
    input wire logic [DATA_W-1:0] INSTR_IMM,
    input wire logic [AUX_IW-1:0] INSTR_AUX_IDX,
    input wire logic [PC_W-1:0] INSTR_TARGET,
    // Completion
    output logic BUSY,
    output logic DONE,
    // Core state
    output logic [DATA_W-1:0] WORK,
    output logic ZERO,
    output logic [PC_W-1:0] PC,
    output logic [SP_W-1:0] STACK_PTR,
    // File register write port
    output logic FILE_WE,
    output logic [FILE_AW-1:0] FILE_WADDR,
    output logic [DATA_W-1:0] FILE_WDATA
);

    // ==========================================================
    // Helpers
    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return (v == '0);
    endfunction

    function automatic logic [PC_W-1:0] pc_next(input logic [PC_W-1:0] v);
        return v + PC_STEP;
    endfunction

    // ==========================================================
    // State
    typedef struct packed {
        orx_state_t state;
        logic [DATA_W-1:0] work;
        logic zero;
        logic [PC_W-1:0] pc;
        logic [SP_W-1:0] sp;
        logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
        logic [PC_W-1:0] target;
        logic busy;
        logic done;
        logic file_we;
        logic [FILE_AW-1:0] file_waddr;
        logic [DATA_W-1:0] file_wdata;
    } orx_core_state_t;

    orx_core_state_t st_r;
    orx_core_state_t st_nxt;

    orx_aux_if aux_bus ();

    orx_aux_page u_aux_page (
        .clk(CORE_CLK),
        .nrst(NRST),
        .aux(aux_bus.page)
    );

    logic take;
    logic [DATA_W-1:0] or_file;
    logic [DATA_W-1:0] or_lit;

    assign take = INSTR_VALID && (st_r.state == ST_ISSUE);
    assign or_file = st_r.work | INSTR_FILE_DATA;
    assign or_lit = st_r.work | INSTR_IMM;

    // Read index follows the issue port directly so the load fits in one cycle
    assign aux_bus.rd_idx = INSTR_AUX_IDX;
    assign aux_bus.wr_idx = INSTR_AUX_IDX;
    assign aux_bus.wr_data = st_r.work;
    assign aux_bus.wr_en = take && (INSTR_OP == OP_AUX_PAGE_STORE_FROM_WORK);

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.file_we = 1'b0;
        unique case (st_r.state)
            ST_ISSUE: begin
                if (take) begin
                    case (INSTR_OP)
                        OP_OR_WORK_WITH_FILE: begin
                            if (INSTR_DEST) begin
                                st_nxt.file_we = 1'b1;
                                st_nxt.file_waddr = INSTR_FILE_ADDR;
                                st_nxt.file_wdata = or_file;
                            end else begin
                                st_nxt.work = or_file;
                            end
                            st_nxt.zero = is_zero(or_file);
                            st_nxt.pc = pc_next(st_r.pc);
                            st_nxt.done = 1'b1;
                        end
                        OP_OR_WORK_WITH_LITERAL: begin
                            st_nxt.work = or_lit;
                            st_nxt.zero = is_zero(or_lit);
                            st_nxt.pc = pc_next(st_r.pc);
                            st_nxt.done = 1'b1;
                        end
                        OP_AUX_PAGE_LOAD_TO_WORK: begin
                            // Indices below the readable range are dropped untouched
                            if (INSTR_AUX_IDX >= AUX_LOAD_MIN) begin
                                st_nxt.work = aux_bus.rd_data;
                                st_nxt.pc = pc_next(st_r.pc);
                                st_nxt.done = 1'b1;
                            end
                        end
                        OP_AUX_PAGE_STORE_FROM_WORK: begin
                            st_nxt.pc = pc_next(st_r.pc);
                            st_nxt.done = 1'b1;
                        end
                        OP_LONG_SUBROUTINE_JUMP: begin
                            // Push first; stack wraps on overflow, as a small core would
                            st_nxt.stack[st_r.sp] = pc_next(st_r.pc);
                            st_nxt.sp = st_r.sp + SP_STEP;
                            st_nxt.target = INSTR_TARGET;
                            st_nxt.busy = 1'b1;
                            st_nxt.state = ST_CALL_LOAD;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_CALL_LOAD: begin
                st_nxt.pc = st_r.target;
                st_nxt.done = 1'b1;
                st_nxt.busy = 1'b0;
                st_nxt.state = ST_ISSUE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            st_r <= '{state: ST_ISSUE, work: '0, zero: 1'b0, pc: PC_RESET, sp: '0,
                      stack: '0, target: '0, busy: 1'b0, done: 1'b0, file_we: 1'b0,
                      file_waddr: '0, file_wdata: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign BUSY = st_r.busy;
    assign DONE = st_r.done;
    assign WORK = st_r.work;
    assign ZERO = st_r.zero;
    assign PC = st_r.pc;
    assign STACK_PTR = st_r.sp;
    assign FILE_WE = st_r.file_we;
    assign FILE_WADDR = st_r.file_waddr;
    assign FILE_WDATA = st_r.file_wdata;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    a_or_file_work: assert property (
        take && INSTR_OP == OP_OR_WORK_WITH_FILE && !INSTR_DEST
        |=> WORK == ($past(WORK) | $past(INSTR_FILE_DATA)) && !FILE_WE)
        else $error("OR with file to work gave wrong result");

    a_or_file_dest: assert property (
        take && INSTR_OP == OP_OR_WORK_WITH_FILE && INSTR_DEST
        |=> FILE_WE && FILE_WADDR == $past(INSTR_FILE_ADDR)
            && FILE_WDATA == ($past(WORK) | $past(INSTR_FILE_DATA)) && $stable(WORK))
        else $error("OR with file to register gave wrong write");

    a_or_file_time: assert property (
        take && INSTR_OP == OP_OR_WORK_WITH_FILE
        |=> DONE && !BUSY && PC == $past(PC) + PC_STEP
            && ZERO == (($past(WORK) | $past(INSTR_FILE_DATA)) == 8'h00))
        else $error("OR with file did not finish in one cycle");

    a_or_lit_value: assert property (
        take && INSTR_OP == OP_OR_WORK_WITH_LITERAL
        |=> WORK == ($past(WORK) | $past(INSTR_IMM)) && DONE)
        else $error("OR with literal gave wrong result");

    a_zero_flag: assert property (
        take && (INSTR_OP == OP_OR_WORK_WITH_LITERAL)
        |=> ZERO == (($past(WORK) | $past(INSTR_IMM)) == 8'h00))
        else $error("Zero flag does not match result");

    a_aux_load: assert property (
        take && INSTR_OP == OP_AUX_PAGE_LOAD_TO_WORK && INSTR_AUX_IDX >= AUX_LOAD_MIN
        |=> WORK == $past(aux_bus.rd_data) && $stable(ZERO) && DONE)
        else $error("Aux page load wrong");

    a_aux_load_drop: assert property (
        take && INSTR_OP == OP_AUX_PAGE_LOAD_TO_WORK && INSTR_AUX_IDX < AUX_LOAD_MIN
        |=> !DONE && $stable(WORK) && $stable(PC) && $stable(ZERO))
        else $error("Aux page load outside readable range changed state");

    a_aux_store: assert property (
        take && INSTR_OP == OP_AUX_PAGE_STORE_FROM_WORK
        |=> $stable(WORK) && $stable(ZERO) && DONE
            && u_aux_page.st_r.regs[$past(INSTR_AUX_IDX)] == $past(WORK))
        else $error("Aux page store wrong");

    a_call_push: assert property (
        take && INSTR_OP == OP_LONG_SUBROUTINE_JUMP
        |=> BUSY && !DONE && STACK_PTR == $past(STACK_PTR) + SP_STEP
            && st_r.stack[$past(STACK_PTR)] == $past(PC) + PC_STEP)
        else $error("Long call push wrong");

    a_call_target: assert property (
        take && INSTR_OP == OP_LONG_SUBROUTINE_JUMP
        |-> ##2 PC == $past(INSTR_TARGET, 2) && DONE && !BUSY
            && ZERO == $past(ZERO, 2))
        else $error("Long call target or timing wrong");

    c_or_file_reg: cover property (take && INSTR_OP == OP_OR_WORK_WITH_FILE && INSTR_DEST);
    c_aux_load: cover property (take && INSTR_OP == OP_AUX_PAGE_LOAD_TO_WORK);
    c_call: cover property (take && INSTR_OP == OP_LONG_SUBROUTINE_JUMP ##2 DONE);
    c_zero_set: cover property (DONE && ZERO);

endmodule

// ===== bench/tb_or_sfr_move_call_exec.sv
`timescale 1ns/1ns
module tb_or_sfr_move_call_exec import orx_pkg::*;;
    typedef struct {logic [7:0] w; logic z; logic [9:0] pc; logic [1:0] sp;
        logic we; logic [5:0] wa; logic [7:0] wd;} orx_exp_t;
    // ==========================================================
    // Stimulus and observed signals
    logic CORE_CLK = 1'b0;
    logic NRST = 1'b0;
    logic INSTR_VALID = 1'b0;
    orx_op_t INSTR_OP = OP_OR_WORK_WITH_FILE;
    logic [5:0] INSTR_FILE_ADDR = 6'h00;
    logic [7:0] INSTR_FILE_DATA = 8'h00;
    logic INSTR_DEST = 1'b0;
    logic [7:0] INSTR_IMM = 8'h00;
    logic [3:0] INSTR_AUX_IDX = 4'h0;
    logic [9:0] INSTR_TARGET = 10'h000;
    logic BUSY, DONE, ZERO, FILE_WE;
    logic [7:0] WORK, FILE_WDATA;
    logic [9:0] PC;
    logic [1:0] STACK_PTR;
    logic [5:0] FILE_WADDR;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    orx_exp_t exp_q[$];
    orx_exp_t cur;
    // Bench copy of the core state, advanced only by instructions that are taken
    orx_exp_t m = '{8'h00, 1'b0, 10'h000, 2'h0, 1'b0, 6'h00, 8'h00};
    logic [7:0] aux_m[16] = '{default: 8'h00};

    orx_exec orx_exec_i (.CORE_CLK(CORE_CLK), .NRST(NRST), .INSTR_VALID(INSTR_VALID),
        .INSTR_OP(INSTR_OP), .INSTR_FILE_ADDR(INSTR_FILE_ADDR),
        .INSTR_FILE_DATA(INSTR_FILE_DATA), .INSTR_DEST(INSTR_DEST), .INSTR_IMM(INSTR_IMM),
        .INSTR_AUX_IDX(INSTR_AUX_IDX), .INSTR_TARGET(INSTR_TARGET), .BUSY(BUSY), .DONE(DONE),
        .WORK(WORK), .ZERO(ZERO), .PC(PC), .STACK_PTR(STACK_PTR), .FILE_WE(FILE_WE),
        .FILE_WADDR(FILE_WADDR), .FILE_WDATA(FILE_WDATA));

    initial begin
        forever #4 CORE_CLK = ~CORE_CLK;
    end

    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            complete_run();
        end
    end

    // ==========================================================
    // Result watcher: every completion consumes the oldest note
    always @(negedge CORE_CLK) begin
        if (NRST && DONE === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected DONE", 10'h000, 10'h001);
            end else begin
                cur = exp_q.pop_front();
                chk("WORK", 10'(cur.w), 10'(WORK));
                chk("ZERO", 10'(cur.z), 10'(ZERO));
                chk("PC", cur.pc, PC);
                chk("STACK_PTR", 10'(cur.sp), 10'(STACK_PTR));
                chk("FILE_WE", 10'(cur.we), 10'(FILE_WE));
                chk("FILE_WADDR", 10'(cur.wa), 10'(FILE_WADDR));
                chk("FILE_WDATA", 10'(cur.wd), 10'(FILE_WDATA));
            end
        end
    end

    // Drive at the falling edge; taken at the next rising edge
    task automatic issue(input logic [2:0] op, input logic [5:0] fa, input logic [7:0] fd,
        input logic d, input logic [7:0] imm, input logic [3:0] f, input logic [9:0] tg);
        logic take;
        logic [7:0] r;
        take = 1'b1;
        m.we = 1'b0;
        r = (op == 3'h0) ? (m.w | fd) : (m.w | imm);
        case (op)
            3'h0, 3'h1: begin
                m.z = (r == 8'h00);
                if (op == 3'h0 && d) begin
                    m.we = 1'b1;
                    m.wa = fa;
                    m.wd = r;
                end else begin
                    m.w = r;
                end
            end
            3'h2: begin
                if (f < 4'h5) take = 1'b0;
                else m.w = aux_m[f];
            end
            3'h3: aux_m[f] = m.w;
            3'h4: m.sp = m.sp + 2'h1;
            default: take = 1'b0;
        endcase
        if (take) begin
            m.pc = (op == 3'h4) ? tg : m.pc + 10'h001;
            exp_q.push_back(m);
        end
        INSTR_VALID = 1'b1;
        INSTR_OP = orx_op_t'(op);
        INSTR_FILE_ADDR = fa;
        INSTR_FILE_DATA = fd;
        INSTR_DEST = d;
        INSTR_IMM = imm;
        INSTR_AUX_IDX = f;
        INSTR_TARGET = tg;
        @(negedge CORE_CLK);
        if (op == 3'h4) begin
            INSTR_VALID = 1'b0;
            chk("BUSY", 10'h001, 10'(BUSY));
            chk("DONE", 10'h000, 10'(DONE));
            @(negedge CORE_CLK);
            chk("BUSY", 10'h000, 10'(BUSY));
            chk("DONE", 10'h001, 10'(DONE));
        end else begin
            chk("DONE", 10'(take), 10'(DONE));
        end
    endtask

    initial begin
        void'($urandom(6));
        repeat (4) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        NRST = 1'b1;
        chk("PC after reset", 10'h000, PC);
        chk("WORK after reset", 10'h000, 10'(WORK));
        issue(3'h1, 6'h00, 8'h00, 1'b0, 8'h00, 4'h0, 10'h000);
        issue(3'h0, 6'h3F, 8'h50, 1'b1, 8'h00, 4'h0, 10'h000);
        issue(3'h1, 6'h00, 8'h00, 1'b0, 8'hAA, 4'h0, 10'h000);
        issue(3'h0, 6'h00, 8'h50, 1'b0, 8'h00, 4'h0, 10'h000);
        issue(3'h3, 6'h00, 8'h00, 1'b0, 8'h00, 4'h0, 10'h000);
        issue(3'h3, 6'h00, 8'h00, 1'b0, 8'h00, 4'hF, 10'h000);
        issue(3'h2, 6'h00, 8'h00, 1'b0, 8'h00, 4'h4, 10'h000);
        issue(3'h2, 6'h00, 8'h00, 1'b0, 8'h00, 4'h5, 10'h000);
        issue(3'h2, 6'h00, 8'h00, 1'b0, 8'h00, 4'hF, 10'h000);
        issue(3'h5, 6'h00, 8'h00, 1'b0, 8'h00, 4'h0, 10'h000);
        // Five calls wrap the four-deep stack pointer
        for (int i = 0; i < 5; i++) begin
            issue(3'h4, 6'h00, 8'h00, 1'b0, 8'h00, 4'h0, 10'(i * 255 + 3));
        end
        issue(3'h4, 6'h00, 8'h00, 1'b0, 8'h00, 4'h0, 10'h000);
        for (int i = 0; i < 60; i++) begin
            issue(3'($urandom_range(0, 4)), 6'($urandom), 8'($urandom), 1'($urandom),
                8'($urandom & 32'h11), 4'($urandom), 10'($urandom));
        end
        INSTR_VALID = 1'b0;
        repeat (3) @(negedge CORE_CLK);
        chk("pending notes", 10'h000, 10'(exp_q.size()));
        complete_run();
    end
endmodule
